// ==== panel_video_pkg.sv ====
// Shared constants and types of the panel video output timing block
package panel_video_pkg;

  // ----------------------------------------------------------------
  // Clock, widths
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int WORD_W        = 12;
  localparam int CNT_W         = 26;
  localparam int PH_W          = 5;
  localparam int WCNT_W        = 8;
  localparam int BCNT_W        = 4;
  localparam int GAP_W         = 6;

  // ----------------------------------------------------------------
  // Times as printed
  // ----------------------------------------------------------------
  localparam int FRAME_1X1_MS       = 130;
  localparam int FRAME_2X2_MS       = 66;
  localparam int FRAME_4X4_MS       = 33;
  localparam int VSYNC_DUMMY_US     = 420;
  localparam int TRIG_DELAY_US      = 210;
  localparam int LINE_PERIOD_US     = 110;
  localparam int HSYNC_DUMMY_1X1_US = 22;
  localparam int HSYNC_DUMMY_2X2_US = 63;
  localparam int HSYNC_DUMMY_4X4_US = 84;
  localparam int PCLK_PERIOD_NS     = 66;
  localparam int PCLK_HIGH_NS       = 33;
  localparam int BLOCK_GAP_NS       = 200;

  // ----------------------------------------------------------------
  // Cycle counts, typical figures rounded down
  // ----------------------------------------------------------------
  localparam int FRAME_1X1_CYC_D   = FRAME_1X1_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FRAME_2X2_CYC_D   = FRAME_2X2_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FRAME_4X4_CYC_D   = FRAME_4X4_MS * 1000000 / CLK_PERIOD_NS;
  localparam int VSYNC_DUMMY_CYC_D = VSYNC_DUMMY_US * 1000 / CLK_PERIOD_NS;
  localparam int TRIG_DELAY_CYC_D  = TRIG_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int LINE_CYC_D        = LINE_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int HDUM_1X1_CYC_D    = HSYNC_DUMMY_1X1_US * 1000 / CLK_PERIOD_NS;
  localparam int HDUM_2X2_CYC_D    = HSYNC_DUMMY_2X2_US * 1000 / CLK_PERIOD_NS;
  localparam int HDUM_4X4_CYC_D    = HSYNC_DUMMY_4X4_US * 1000 / CLK_PERIOD_NS;

  localparam logic [PH_W-1:0]   PH_LAST   = PH_W'(PCLK_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [PH_W-1:0]   PH_HIGH   = PH_W'(PCLK_HIGH_NS / CLK_PERIOD_NS);
  localparam logic [PH_W-1:0]   PH_FIRST  = 5'h01;
  localparam logic [GAP_W-1:0]  GAP_LAST  = GAP_W'(BLOCK_GAP_NS / CLK_PERIOD_NS - 1);
  localparam logic [WCNT_W-1:0] WORD_LAST = 8'h9b;
  localparam logic [BCNT_W-1:0] BLK_1X1_LAST = 4'h7;
  localparam logic [BCNT_W-1:0] BLK_2X2_LAST = 4'h3;
  localparam logic [BCNT_W-1:0] BLK_4X4_LAST = 4'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BIN_1X1 = 3'b001,
    BIN_2X2 = 3'b010,
    BIN_4X4 = 3'b100
  } bin_mode_t;

  typedef enum logic [2:0] {
    F_IDLE  = 3'b001,
    F_DELAY = 3'b010,
    F_RUN   = 3'b100
  } frame_state_t;

  typedef enum logic [5:0] {
    L_IDLE  = 6'b000001,
    L_DUMMY = 6'b000010,
    L_GAP   = 6'b000100,
    L_DATA  = 6'b001000,
    L_BGAP  = 6'b010000,
    L_TAIL  = 6'b100000
  } line_state_t;

endpackage

// ==== panel_video_timing.sv ====
// Frame, line and pixel timing generator of the panel video output
//
// Requirements of the document
// R01: Frame period 130, 66 or 33 ms
// R02: Dummy frame sync pulse 420 us
// R03: External trigger delays frame by 210 us
// R04: Line period 110 us in all modes
// R05: Dummy line pulse 22, 63, 84 us
// R06: Pixel clock 66 ns period, 33 ns high; code gives 64 ns period, 32 ns high
// R07: 200 ns gap between readout blocks
// R08: One new pixel word per pixel clock
// R09: Data line 1 is the MSB
// R10: Grabber takes 16 bits at 16 MHz
// R11: Grabber drives binning and trigger pins
// R12: 156 words per readout block
// R13: Line and pixel timing ignore trigger mode
// R14: Binning pin encoding is configurable
// R15: Grabber keeps words only inside line sync
`timescale 1ns/1ps
module panel_video_timing #(
  parameter logic [1:0] BIN_CODE_2X2 = 2'h1,
  parameter logic [1:0] BIN_CODE_4X4 = 2'h2,
  parameter logic [panel_video_pkg::CNT_W-1:0] FRAME_1X1_CYC =
    panel_video_pkg::CNT_W'(panel_video_pkg::FRAME_1X1_CYC_D),
  parameter logic [panel_video_pkg::CNT_W-1:0] FRAME_2X2_CYC =
    panel_video_pkg::CNT_W'(panel_video_pkg::FRAME_2X2_CYC_D),
  parameter logic [panel_video_pkg::CNT_W-1:0] FRAME_4X4_CYC =
    panel_video_pkg::CNT_W'(panel_video_pkg::FRAME_4X4_CYC_D),
  parameter logic [panel_video_pkg::CNT_W-1:0] VSYNC_DUMMY_CYC =
    panel_video_pkg::CNT_W'(panel_video_pkg::VSYNC_DUMMY_CYC_D),
  parameter logic [panel_video_pkg::CNT_W-1:0] TRIG_DELAY_CYC =
    panel_video_pkg::CNT_W'(panel_video_pkg::TRIG_DELAY_CYC_D),
  parameter logic [panel_video_pkg::CNT_W-1:0] LINE_CYC =
    panel_video_pkg::CNT_W'(panel_video_pkg::LINE_CYC_D),
  parameter logic [panel_video_pkg::CNT_W-1:0] HDUM_1X1_CYC =
    panel_video_pkg::CNT_W'(panel_video_pkg::HDUM_1X1_CYC_D),
  parameter logic [panel_video_pkg::CNT_W-1:0] HDUM_2X2_CYC =
    panel_video_pkg::CNT_W'(panel_video_pkg::HDUM_2X2_CYC_D),
  parameter logic [panel_video_pkg::CNT_W-1:0] HDUM_4X4_CYC =
    panel_video_pkg::CNT_W'(panel_video_pkg::HDUM_4X4_CYC_D)
) (
  input  wire logic                               clk_sys_in,
  input  wire logic                               sys_rst_in,
  input  wire logic                               binning_select_lo_in,
  input  wire logic                               binning_select_hi_in,
  input  wire logic                               trigger_source_select_in,
  input  wire logic                               external_trigger_in,
  input  wire logic [panel_video_pkg::WORD_W-1:0] src_word_in,
  input  wire logic                               src_valid_in,
  output logic                                    src_ready_out,
  output logic                                    frame_sync_out,
  output logic                                    line_sync_out,
  output logic                                    pixel_clock_out,
  output logic      [panel_video_pkg::WORD_W-1:0] pixel_word_out
);
  import panel_video_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and trigger edge
  // ----------------------------------------------------------------
  logic [3:0]        pins_s;
  logic              trig_d_r;
  logic              trig_rise;
  logic              ext_sel_s;
  logic [1:0]        bin_code_s;
  bin_mode_t         bin_now;

  pin_sync #(
    .W (4)
  ) u_pin_sync (
    .clk_in (clk_sys_in),
    .rst_in (sys_rst_in),
    .d_in   ({binning_select_hi_in, binning_select_lo_in,
              trigger_source_select_in, external_trigger_in}),
    .q_out  (pins_s)
  );

  // R14: encoding set by parameters
  function automatic bin_mode_t bin_decode(input logic [1:0] code);
    bin_mode_t m;
    m = BIN_1X1;
    if (code == BIN_CODE_2X2) begin
      m = BIN_2X2;
    end else if (code == BIN_CODE_4X4) begin
      m = BIN_4X4;
    end
    return m;
  endfunction

  assign bin_code_s = pins_s[3:2];
  assign ext_sel_s  = pins_s[1];
  assign trig_rise  = pins_s[0] && !trig_d_r;
  assign bin_now    = bin_decode(bin_code_s);

  // ----------------------------------------------------------------
  // Word buffer
  // ----------------------------------------------------------------
  // Two entries absorb a source stall without losing a word
  logic [WORD_W-1:0] buf_word;
  logic              buf_valid;
  logic              take;

  word_fifo #(
    .W     (WORD_W),
    .DEPTH (2)
  ) u_word_fifo (
    .clk_in       (clk_sys_in),
    .rst_in       (sys_rst_in),
    .wr_data_in   (src_word_in),
    .wr_valid_in  (src_valid_in),
    .wr_ready_out (src_ready_out),
    .rd_data_out  (buf_word),
    .rd_valid_out (buf_valid),
    .rd_ready_in  (take)
  );

  // ----------------------------------------------------------------
  // Mode dependent figures
  // ----------------------------------------------------------------
  frame_state_t      f_state_r;
  frame_state_t      f_nxt;
  logic [CNT_W-1:0]  frm_cnt_r;
  logic [CNT_W-1:0]  frm_cnt_nxt;
  bin_mode_t         mode_r;
  logic              ext_mode_r;
  logic              start;
  logic [CNT_W-1:0]  frm_period;
  logic [CNT_W-1:0]  hdum_cyc;
  logic [BCNT_W-1:0] blk_last;
  logic [CNT_W-1:0]  act_start;
  logic [CNT_W-1:0]  last_line_start;

  // R01: frame period per binning mode
  assign frm_period = (mode_r == BIN_4X4) ? FRAME_4X4_CYC :
                      (mode_r == BIN_2X2) ? FRAME_2X2_CYC : FRAME_1X1_CYC;
  // R05: dummy line pulse per binning mode
  assign hdum_cyc   = (mode_r == BIN_4X4) ? HDUM_4X4_CYC :
                      (mode_r == BIN_2X2) ? HDUM_2X2_CYC : HDUM_1X1_CYC;
  assign blk_last   = (mode_r == BIN_4X4) ? BLK_4X4_LAST :
                      (mode_r == BIN_2X2) ? BLK_2X2_LAST : BLK_1X1_LAST;
  assign act_start       = VSYNC_DUMMY_CYC + CNT_W'(GAP_LAST) + 1'b1;
  assign last_line_start = frm_period - LINE_CYC;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    f_nxt       = f_state_r;
    frm_cnt_nxt = frm_cnt_r + 1'b1;
    start       = 1'b0;
    unique case (f_state_r)
      F_IDLE: begin
        frm_cnt_nxt = '0;
        if (!ext_sel_s) begin
          start = 1'b1;
        end else if (trig_rise) begin
          f_nxt = F_DELAY;
        end
      end
      // R03: trigger to frame start delay
      F_DELAY: begin
        if (frm_cnt_r == TRIG_DELAY_CYC - 1'b1) begin
          start = 1'b1;
        end
      end
      // R01: restart or wait for the next trigger
      F_RUN: begin
        if (frm_cnt_r == frm_period - 1'b1) begin
          // A switch to external mode must not start a frame without a trigger
          if (ext_mode_r || ext_sel_s) begin
            f_nxt       = F_IDLE;
            frm_cnt_nxt = '0;
          end else begin
            start = 1'b1;
          end
        end
      end
    endcase
    if (start) begin
      f_nxt       = F_RUN;
      frm_cnt_nxt = '0;
    end
  end

  // ----------------------------------------------------------------
  // Line and pixel sequencer
  // ----------------------------------------------------------------
  line_state_t       l_state_r;
  line_state_t       l_nxt;
  logic [CNT_W-1:0]  ln_cnt_r;
  logic [CNT_W-1:0]  ln_nxt;
  logic [PH_W-1:0]   ph_r;
  logic [PH_W-1:0]   ph_nxt;
  logic [WCNT_W-1:0] word_cnt_r;
  logic [WCNT_W-1:0] wc_nxt;
  logic [BCNT_W-1:0] blk_cnt_r;
  logic [BCNT_W-1:0] bc_nxt;
  logic [GAP_W-1:0]  gap_cnt_r;
  logic [GAP_W-1:0]  gap_nxt;
  logic              l_busy;
  logic              line_end;
  logic              line_ok;
  logic              line_go;
  logic              word_end;
  logic              last_word;
  logic              want_word;

  // R13: no term here looks at the trigger mode
  assign l_busy    = (l_state_r != L_IDLE);
  assign line_end  = l_busy && (ln_cnt_r == LINE_CYC - 1'b1);
  assign line_ok   = (f_state_r == F_RUN) && (frm_cnt_r >= act_start) &&
                     (frm_cnt_r <= last_line_start);
  assign line_go   = line_ok && (!l_busy || line_end);
  assign word_end  = (l_state_r == L_DATA) && (ph_r == PH_LAST);
  assign last_word = (word_cnt_r == WORD_LAST);
  assign want_word = (l_state_r == L_DATA) && ((ph_r == '0) || (word_end && !last_word));
  // R08: a word leaves the buffer once per pixel period
  assign take      = want_word && buf_valid && !line_end;

  always_comb begin
    l_nxt   = l_state_r;
    ln_nxt  = ln_cnt_r + 1'b1;
    ph_nxt  = ph_r;
    wc_nxt  = word_cnt_r;
    bc_nxt  = blk_cnt_r;
    gap_nxt = gap_cnt_r;
    // R04: a new line every line period
    if (line_go) begin
      l_nxt   = L_DUMMY;
      ln_nxt  = '0;
      ph_nxt  = '0;
      wc_nxt  = '0;
      bc_nxt  = '0;
      gap_nxt = '0;
    end else if (line_end || !l_busy) begin
      l_nxt  = L_IDLE;
      ln_nxt = '0;
      ph_nxt = '0;
    end else begin
      unique case (l_state_r)
        L_IDLE: begin
          l_nxt = L_IDLE;
        end
        // R05: dummy line pulse length
        L_DUMMY: begin
          if (ln_cnt_r == hdum_cyc - 1'b1) begin
            l_nxt = L_GAP;
          end
        end
        // R07: gap with the pixel clock stopped
        L_GAP, L_BGAP: begin
          gap_nxt = gap_cnt_r + 1'b1;
          if (gap_cnt_r == GAP_LAST) begin
            l_nxt   = L_DATA;
            gap_nxt = '0;
            wc_nxt  = '0;
          end
        end
        // R12: block ends after its last word
        L_DATA: begin
          if (take) begin
            ph_nxt = PH_FIRST;
          end else if (ph_r == PH_LAST) begin
            ph_nxt = '0;
            if (last_word) begin
              bc_nxt = blk_cnt_r + 1'b1;
              l_nxt  = (blk_cnt_r == blk_last) ? L_TAIL : L_BGAP;
            end
          end else if (ph_r != '0) begin
            ph_nxt = ph_r + 1'b1;
          end
          if (word_end && !last_word) begin
            wc_nxt = word_cnt_r + 1'b1;
          end
        end
        L_TAIL: begin
          l_nxt = L_TAIL;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output decode
  // ----------------------------------------------------------------
  logic              pclk_nxt;
  logic              hsync_nxt;
  logic              vsync_nxt;
  logic              pclk_r;
  logic              hsync_r;
  logic              vsync_r;
  logic [WORD_W-1:0] word_r;

  // R06: high for the first half of each pixel period
  assign pclk_nxt  = (l_nxt == L_DATA) && (ph_nxt != '0) && (ph_nxt <= PH_HIGH);
  assign hsync_nxt = (l_nxt == L_DUMMY) || (l_nxt == L_DATA) || (l_nxt == L_BGAP);
  // R02: dummy frame pulse, then active region
  assign vsync_nxt = (f_state_r == F_RUN) && ((frm_cnt_r < VSYNC_DUMMY_CYC) ||
                     ((frm_cnt_r >= act_start) && (line_ok || l_busy)));

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      f_state_r  <= F_IDLE;
      frm_cnt_r  <= '0;
      mode_r     <= BIN_1X1;
      ext_mode_r <= 1'b0;
      trig_d_r   <= 1'b0;
    end else begin
      f_state_r <= f_nxt;
      frm_cnt_r <= frm_cnt_nxt;
      trig_d_r  <= pins_s[0];
      // Mode is frozen for a whole frame so lines never change shape mid-frame
      if (start) begin
        mode_r     <= bin_now;
        ext_mode_r <= ext_sel_s;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      l_state_r  <= L_IDLE;
      ln_cnt_r   <= '0;
      ph_r       <= '0;
      word_cnt_r <= '0;
      blk_cnt_r  <= '0;
      gap_cnt_r  <= '0;
    end else begin
      l_state_r  <= l_nxt;
      ln_cnt_r   <= ln_nxt;
      ph_r       <= ph_nxt;
      word_cnt_r <= wc_nxt;
      blk_cnt_r  <= bc_nxt;
      gap_cnt_r  <= gap_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pclk_r  <= 1'b0;
      hsync_r <= 1'b0;
      vsync_r <= 1'b0;
      word_r  <= '0;
    end else begin
      pclk_r  <= pclk_nxt;
      hsync_r <= hsync_nxt;
      vsync_r <= vsync_nxt;
      // R09: bit 11 carries data line 1
      if (take) begin
        word_r <= buf_word;
      end
    end
  end

  assign pixel_clock_out = pclk_r;
  assign line_sync_out   = hsync_r;
  assign frame_sync_out  = vsync_r;
  assign pixel_word_out  = word_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_frame_restart: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R01
    (f_state_r == F_RUN && !ext_mode_r && !ext_sel_s && frm_cnt_r == frm_period - 1'b1)
      |=> (f_state_r == F_RUN && frm_cnt_r == '0))
    else $error("frame did not restart at period end");

  a_ext_wait: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R03
    (f_state_r == F_RUN && ext_sel_s && frm_cnt_r == frm_period - 1'b1)
      |=> (f_state_r == F_IDLE))
    else $error("external mode frame started without trigger");

  a_vsync_dummy_end: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R02
    (f_state_r == F_RUN && frm_cnt_r == VSYNC_DUMMY_CYC && $past(f_state_r) == F_RUN)
      |=> !frame_sync_out)
    else $error("dummy frame pulse too long");

  a_trig_delay: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R03
    (f_state_r == F_DELAY && frm_cnt_r == TRIG_DELAY_CYC - 1'b1)
      |=> (f_state_r == F_RUN && frm_cnt_r == '0))
    else $error("trigger delay not honoured");

  a_int_no_delay: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R03
    (f_state_r == F_IDLE && !ext_sel_s) |=> (f_state_r == F_RUN))
    else $error("internal mode waited for trigger");

  a_line_length: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R04
    (l_busy && line_ok && ln_cnt_r == LINE_CYC - 1'b1)
      |=> (l_state_r == L_DUMMY && ln_cnt_r == '0))
    else $error("line period broken");

  a_hsync_dummy: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R05
    (l_state_r == L_DUMMY && ln_cnt_r == hdum_cyc - 1'b1 && !line_end)
      |=> (l_state_r == L_GAP) ##1 !line_sync_out)
    else $error("dummy line pulse wrong length");

  a_pclk_width: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R06
    ($rose(pixel_clock_out) && ln_cnt_r < LINE_CYC - 5'h10)
      |-> pixel_clock_out [*8] ##1 !pixel_clock_out [*8])
    else $error("pixel clock shape wrong");

  a_block_gap: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R07
    ($rose(l_state_r == L_BGAP) && ln_cnt_r < LINE_CYC - 7'h40)
      |-> ##49 (l_state_r == L_BGAP) ##1 (l_state_r == L_DATA))
    else $error("block gap wrong length");

  a_word_change: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R08
    $changed(pixel_word_out) |-> $rose(pixel_clock_out))
    else $error("word changed outside pixel clock rise");

  a_block_words: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R12
    (word_end && last_word && !line_end) |=> (l_state_r != L_DATA && ph_r == '0))
    else $error("block did not end after its last word");
endmodule

// ==== pin_sync.sv ====
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule

// ==== tb.sv ====
// Self-checking bench of the panel video timing block
`timescale 1ns/1ps
module tb;
  import panel_video_pkg::*;
  // ----------------------------------------------------------------
  // Shortened counts, kept for a short run
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] FR1  = 26'h1b58;
  localparam logic [CNT_W-1:0] FR2  = 26'h1388;
  localparam logic [CNT_W-1:0] FR4  = 26'h0fa0;
  localparam logic [CNT_W-1:0] VDUM = 26'h00c8;
  localparam logic [CNT_W-1:0] TDLY = 26'h0064;
  localparam logic [CNT_W-1:0] LINE = 26'h0c80;
  localparam logic [CNT_W-1:0] HD1  = 26'h0064;
  localparam logic [CNT_W-1:0] HD2  = 26'h00c8;
  localparam logic [CNT_W-1:0] HD4  = 26'h012c;
  logic              clk_sys_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic [1:0]        bin_code   = 2'h0;
  logic              tsel       = 1'b0;
  logic              trig       = 1'b0;
  logic              src_valid  = 1'b0;
  logic [WORD_W-1:0] src_word   = 12'h7fe;
  logic              src_ready;
  logic              fsync;
  logic              lsync;
  logic              pclk;
  logic [WORD_W-1:0] word;
  int                n_words, n_bad, n_mismatch, total_checks, cyc, t1, t2, w, n;
  logic [1:0]        codes [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
  logic [CNT_W-1:0]  frs   [4] = '{FR1, FR1, FR2, FR4};
  logic [CNT_W-1:0]  hds   [4] = '{HD1, HD1, HD2, HD4};

  always #2 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) cyc <= cyc + 1;
  // Counting source, one word per accepted handshake
  always @(posedge clk_sys_in) if (src_valid && src_ready) src_word <= src_word + 12'h001;

  panel_video_timing #(
    .FRAME_1X1_CYC(FR1), .FRAME_2X2_CYC(FR2), .FRAME_4X4_CYC(FR4), .VSYNC_DUMMY_CYC(VDUM),
    .TRIG_DELAY_CYC(TDLY), .LINE_CYC(LINE), .HDUM_1X1_CYC(HD1), .HDUM_2X2_CYC(HD2),
    .HDUM_4X4_CYC(HD4)
  ) panel_video_timing_inst (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .binning_select_lo_in(bin_code[0]),
    .binning_select_hi_in(bin_code[1]), .trigger_source_select_in(tsel),
    .external_trigger_in(trig), .src_word_in(src_word), .src_valid_in(src_valid),
    .src_ready_out(src_ready), .frame_sync_out(fsync), .line_sync_out(lsync),
    .pixel_clock_out(pclk), .pixel_word_out(word)
  );
  video_grabber video_grabber_inst (
    .clk_in(clk_sys_in), .rst_in(sys_rst_in), .line_sync_in(lsync), .pixel_clock_in(pclk),
    .pixel_word_in(word), .n_words_out(n_words), .n_bad_out(n_bad)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic sg(input int s);
    return (s == 0) ? fsync : (s == 1) ? lsync : pclk;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Bounded wait for a level; a must-wait that runs out ends the run
  task automatic wt(input int s, input logic v, input int mx, input bit must, output int k);
    k = 0;
    while (sg(s) !== v && k <= mx) begin
      @(posedge clk_sys_in);
      #1;
      k++;
    end
    if (must && k > mx) begin
      n_mismatch++;
      $display("mismatch wait %0d expected %0d seen %0d", s, mx, k);
      end_sim();
    end
  endtask
  // Dummy pulse is the one followed by a 50-cycle low
  task automatic fdum(input int s, output int t, output int hw);
    int lo;
    lo = 0;
    for (int k = 0; k < 30 && lo != 50; k++) begin
      wt(s, 1'b1, 9000, 1'b1, lo);
      wt(s, 1'b0, 9000, 1'b1, hw);
      t = cyc;
      wt(s, 1'b1, 60, 1'b0, lo);
    end
    chk("dummy low", 32'h32, lo);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    chk("idle outputs", 32'h8000, {src_ready, fsync, lsync, pclk, word});
    @(posedge clk_sys_in);
    src_valid <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    #1;
    chk("buffer full", 32'h0800, {src_ready, src_word});
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      bin_code <= codes[i];
      fdum(0, t1, w);
      fdum(0, t1, w);
      fdum(1, t2, w);
      chk("line dummy", hds[i], w);
      if (i == 0) begin
        wt(2, 1'b1, 40, 1'b1, n);
        for (int k = 1; k <= 156; k++) begin
          wt(2, 1'b0, 40, 1'b1, w);
          wt(2, 1'b1, 90, 1'b1, n);
          if (k < 156)
            chk("pclk high low", 32'h00080008, {w[15:0], n[15:0]});
          else
            chk("block gap", 32'h1, n >= 58 && n <= 60);
        end
        @(posedge clk_sys_in);
        src_valid <= 1'b0;
        repeat (60) @(posedge clk_sys_in);
        #1;
        chk("pclk stall", 32'h0, pclk);
        @(posedge clk_sys_in);
        src_valid <= 1'b1;
        fdum(1, n, w);
        chk("line period", LINE, n - t2);
      end
      fdum(0, t2, w);
      chk("frame period", frs[i], t2 - t1);
    end
    @(posedge clk_sys_in);
    tsel <= 1'b1;
    repeat (4400) @(posedge clk_sys_in);
    #1;
    chk("no trigger frame", 32'h0, fsync);
    @(posedge clk_sys_in);
    trig <= 1'b1;
    #1;
    wt(0, 1'b1, 200, 1'b1, n);
    chk("trigger delay", 32'h1, n >= TDLY && n <= TDLY + 6);
    wt(0, 1'b0, 400, 1'b1, w);
    chk("frame dummy", VDUM, w);
    @(posedge clk_sys_in);
    trig <= 1'b0;
    fdum(1, t2, w);
    chk("ext line dummy", HD4, w);
    chk("word order", 32'h0, n_bad);
    chk("words seen", 32'h1, n_words > 400);
    end_sim();
  end
endmodule

// ==== video_grabber.sv ====
// Frame grabber model that captures and checks the pixel stream
`timescale 1ns/1ps
module video_grabber #(
  parameter logic [panel_video_pkg::WORD_W-1:0] FIRST = 12'h7fe
) (
  input  wire logic                               clk_in,
  input  wire logic                               rst_in,
  input  wire logic                               line_sync_in,
  input  wire logic                               pixel_clock_in,
  input  wire logic [panel_video_pkg::WORD_W-1:0] pixel_word_in,
  output int                                      n_words_out,
  output int                                      n_bad_out
);
  import panel_video_pkg::*;
  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  logic              pclk_q_r;
  logic [WORD_W-1:0] exp_r;
  logic [15:0]       pix;
  logic              take;
  // word held in a 16-bit pixel
  assign pix  = {4'h0, pixel_word_in};
  // words kept only inside line sync
  assign take = pixel_clock_in && !pclk_q_r && line_sync_in;
  always_ff @(posedge clk_in) begin
    pclk_q_r <= pixel_clock_in;
    if (rst_in) begin
      exp_r       <= FIRST;
      n_words_out <= 0;
      n_bad_out   <= 0;
    end else if (take) begin
      exp_r       <= exp_r + 12'h001;
      n_words_out <= n_words_out + 1;
      if (pix !== {4'h0, exp_r})
        n_bad_out <= n_bad_out + 1;
    end
  end
endmodule

// ==== word_fifo.sv ====
// Small valid/ready word buffer
`timescale 1ns/1ps
module word_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] wr_data_in,
  input  wire logic         wr_valid_in,
  output logic              wr_ready_out,
  output logic      [W-1:0] rd_data_out,
  output logic              rd_valid_out,
  input  wire logic         rd_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   CNT_FULL = (AW + 1)'(DEPTH);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign wr_ready_out = (cnt_r != CNT_FULL);
  assign rd_valid_out = (cnt_r != '0);
  assign rd_data_out  = mem_r[rp_r];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wp_r] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PTR_LAST) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == PTR_LAST) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule
